// [see_regs.svh]
// constants shared by both ends of the serial eeprom link
`ifndef SEE_REGS_SVH
`define SEE_REGS_SVH
`define SEE_DEV_CODE      4'hA
`define SEE_PAGE_BYTES    16
`define SEE_PROT_BIT      7
`define SEE_ACK_BIT       4'h8
`define SEE_REF_PERIOD_NS 40
`define SEE_SCL_PERIOD_NS 320
`define SEE_SCL_QTR_CYC   ((`SEE_SCL_PERIOD_NS / 4) / `SEE_REF_PERIOD_NS)
`define SEE_TWR_NS        1000000
`define SEE_TWR_CYC       ((`SEE_TWR_NS + `SEE_REF_PERIOD_NS - 1) / `SEE_REF_PERIOD_NS)
`endif

// [see_pkg.sv]
// state and stage types of both link ends
package see_pkg;
    typedef enum logic [1:0] {SS_IDLE = 2'b00, SS_RX = 2'b01, SS_ACK = 2'b10} see_slv_state_e;
    typedef enum logic [1:0] {SG_CTRL = 2'b00, SG_ADDR = 2'b01, SG_DATA = 2'b10,
                              SG_READ = 2'b11} see_slv_stage_e;
    typedef enum logic [1:0] {MS_IDLE = 2'b00, MS_START = 2'b01, MS_BIT = 2'b10,
                              MS_STOP = 2'b11} see_mst_state_e;
    typedef enum logic [1:0] {MG_CTRL = 2'b00, MG_ADDR = 2'b01, MG_DATA = 2'b10,
                              MG_POLL = 2'b11} see_mst_stage_e;
endpackage : see_pkg

// [see_bus_if.sv]
// two-wire link between master and eeprom slave, open-drain data resolved here
`timescale 1ns/10ps
interface see_bus_if;
    logic scl;
    logic mSdaOut;
    logic mSdaOe;
    logic sSdaOut;
    logic sSdaOe;
    logic sda;
    // wired-and with pull-up: any enabled low driver wins
    assign sda = ~((mSdaOe & ~mSdaOut) | (sSdaOe & ~sSdaOut));
    modport master (output scl, output mSdaOut, output mSdaOe, input sda);
    modport slave (input scl, input sda, output sSdaOut, output sSdaOe);
endinterface : see_bus_if

// [see_fifo.sv]
// small flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module see_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wrIdx_ff;
    logic [AW-1:0]    rdIdx_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;
    logic [AW:0]      nxt_count;

    // registered flags keep the handshake outputs glitch free
    assign push      = inValid & inReady;
    assign pop       = outValid & outReady;
    assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    assign outData   = mem_ff[rdIdx_ff];

    // storage and pointers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            wrIdx_ff <= '0;
            rdIdx_ff <= '0;
            count_ff <= '0;
            inReady  <= 1'b1;
            outValid <= 1'b0;
            for (int i = 0; i < DEPTH; i++)
                mem_ff[i] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_ff[wrIdx_ff] <= inData;
                wrIdx_ff         <= (wrIdx_ff == AW'(DEPTH - 1)) ? '0 : wrIdx_ff + 1'b1;
            end
            if (pop)
                rdIdx_ff <= (rdIdx_ff == AW'(DEPTH - 1)) ? '0 : rdIdx_ff + 1'b1;
            count_ff <= nxt_count;
            inReady  <= nxt_count != (AW+1)'(DEPTH);
            outValid <= nxt_count != '0;
        end
    end
endmodule : see_fifo

// [see_master.sv]
// two-wire bus master: writes queued bytes, then polls for write completion
`timescale 1ns/10ps
`include "see_regs.svh"
module see_master (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    see_bus_if.master       link,
    input  wire logic [2:0] devSel,
    input  wire logic [7:0] wrData,
    input  wire logic       wrLast,
    input  wire logic       wrValid,
    output logic            wrReady,
    output logic            busy,
    output logic            nackErr
);
    see_pkg::see_mst_state_e state_ff;
    see_pkg::see_mst_stage_e stage_ff;
    logic [3:0] qCnt_ff;
    logic [1:0] phase_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] shift_ff;
    logic       ackBit_ff;
    logic       lastSent_ff;
    logic       drop_ff;
    logic [1:0] sdaSync_ff;
    logic       sclOut_ff;
    logic       sdaOe_ff;
    logic       sdaOut_ff;
    logic [8:0] fifoData;
    logic       fifoValid;
    logic       tick;
    logic       ackEnd;
    logic       wantByte;
    logic       stall;
    logic       advance;
    logic       fifoPop;

    // user bytes pass a small queue; a busy bus pushes back on wrReady once the queue is full
    see_fifo #(.WIDTH(9), .DEPTH(4)) i_see_fifo (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .inData   ({wrLast, wrData}),
        .inValid  (wrValid),
        .inReady  (wrReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    assign link.scl     = sclOut_ff;
    assign link.mSdaOe  = sdaOe_ff;
    assign link.mSdaOut = sdaOut_ff;

    // quarter-period ticks; scl is divided from ref_clk
    assign tick     = qCnt_ff == 4'(`SEE_SCL_QTR_CYC - 1);
    assign ackEnd   = state_ff == see_pkg::MS_BIT && phase_ff == 2'h3
                      && bitCnt_ff == `SEE_ACK_BIT;
    assign wantByte = ackBit_ff && (stage_ff == see_pkg::MG_CTRL
                      || (stage_ff != see_pkg::MG_POLL && !lastSent_ff));
    // hold scl high at the end of the ack slot while the next byte has not arrived
    assign stall    = ackEnd && wantByte && !fifoValid;
    assign advance  = tick && !stall;
    assign fifoPop  = (advance && ackEnd && wantByte)
                      || (state_ff == see_pkg::MS_IDLE && drop_ff && fifoValid);

    // pin sampling and quarter timer
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sdaSync_ff <= 2'h3;
            qCnt_ff    <= 4'h0;
            busy       <= 1'b0;
            sdaOut_ff  <= 1'b0;
        end
        else
        begin
            sdaSync_ff <= {sdaSync_ff[0], link.sda};
            qCnt_ff    <= (state_ff == see_pkg::MS_IDLE || tick) ? 4'h0 : qCnt_ff + 4'h1;
            busy       <= state_ff != see_pkg::MS_IDLE;
        end
    end

    // bus sequencer: start, byte bits with ack slot, stop
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff    <= see_pkg::MS_IDLE;
            stage_ff    <= see_pkg::MG_CTRL;
            phase_ff    <= 2'h0;
            bitCnt_ff   <= 4'h0;
            shift_ff    <= 8'h00;
            ackBit_ff   <= 1'b0;
            lastSent_ff <= 1'b0;
            drop_ff     <= 1'b0;
            sclOut_ff   <= 1'b1;
            sdaOe_ff    <= 1'b0;
            nackErr     <= 1'b0;
        end
        else
        begin
            nackErr <= 1'b0;
            if (fifoPop && state_ff == see_pkg::MS_IDLE && fifoData[8])
                drop_ff <= 1'b0;
            if (state_ff == see_pkg::MS_IDLE)
            begin
                // only start on an idle bus R04 R05
                if (fifoValid && !drop_ff)
                begin
                    state_ff <= see_pkg::MS_START;
                    stage_ff <= see_pkg::MG_CTRL;
                    phase_ff <= 2'h0;
                end
            end
            else if (advance)
            begin
                phase_ff <= phase_ff + 2'h1;
                case (state_ff)
                    see_pkg::MS_START:
                        case (phase_ff)
                            2'h0: sdaOe_ff <= 1'b0;
                            2'h1: sclOut_ff <= 1'b1;
                            2'h2: sdaOe_ff <= 1'b1; // R02
                            default:
                            begin
                                sclOut_ff <= 1'b0;
                                state_ff  <= see_pkg::MS_BIT;
                                bitCnt_ff <= 4'h0;
                                shift_ff  <= {`SEE_DEV_CODE, devSel, 1'b0}; // R11 R21
                            end
                        endcase
                    see_pkg::MS_BIT:
                        case (phase_ff)
                            // data changes only with scl low R01 R06
                            2'h0: sdaOe_ff <= (bitCnt_ff != `SEE_ACK_BIT) & ~shift_ff[7];
                            2'h1: sclOut_ff <= 1'b1;
                            2'h2: ackBit_ff <= ~sdaSync_ff[1]; // R07
                            default:
                            begin
                                sclOut_ff <= 1'b0;
                                if (bitCnt_ff != `SEE_ACK_BIT)
                                begin
                                    shift_ff  <= {shift_ff[6:0], 1'b0};
                                    bitCnt_ff <= bitCnt_ff + 4'h1;
                                end
                                else if (wantByte)
                                begin
                                    shift_ff    <= fifoData[7:0];
                                    lastSent_ff <= fifoData[8];
                                    bitCnt_ff   <= 4'h0;
                                    stage_ff    <= (stage_ff == see_pkg::MG_CTRL)
                                                   ? see_pkg::MG_ADDR : see_pkg::MG_DATA;
                                end
                                else if (!ackBit_ff && (stage_ff == see_pkg::MG_CTRL
                                         || stage_ff == see_pkg::MG_POLL))
                                    state_ff <= see_pkg::MS_START; // R21
                                else
                                begin
                                    state_ff <= see_pkg::MS_STOP;
                                    if (!ackBit_ff)
                                    begin
                                        nackErr  <= 1'b1;
                                        drop_ff  <= !lastSent_ff;
                                        stage_ff <= see_pkg::MG_CTRL;
                                    end
                                    else
                                        stage_ff <= (stage_ff == see_pkg::MG_POLL)
                                                    ? see_pkg::MG_CTRL : see_pkg::MG_POLL;
                                end
                            end
                        endcase
                    see_pkg::MS_STOP:
                        case (phase_ff)
                            2'h0: sdaOe_ff <= 1'b1;
                            2'h1: sclOut_ff <= 1'b1;
                            2'h2: sdaOe_ff <= 1'b0; // R03 R04
                            default:
                                // after a write the cycle time is waited out by polling R20
                                state_ff <= (stage_ff == see_pkg::MG_POLL)
                                            ? see_pkg::MS_START : see_pkg::MS_IDLE;
                        endcase
                    default: state_ff <= see_pkg::MS_IDLE;
                endcase
            end
        end
    end
endmodule : see_master

// [see_slave.sv]
// eeprom slave end: start/stop detection, control decode, page write, write cycle
`timescale 1ns/10ps
`include "see_regs.svh"
// Overview of operation
// (R01) data changes only while clock low
// (R02) falling data with clock high is START
// (R03) rising data with clock high is STOP
// (R04) master frames every command with START, STOP
// (R05) master starts only on an idle bus
// (R06) one bit per clock, stable while high
// (R07) receiver acknowledges every byte, ninth clock
// (R08) acknowledge holds data low through clock high
// (R09) no acknowledge at all while writing
// (R10) release data after master withholds acknowledge
// (R11) control byte: code 1010, selects, direction
// (R12) acknowledge only on code and select match
// (R13) direction one reads, zero writes
// (R14) control, address, data acknowledged; STOP commits
// (R15) up to sixteen page bytes, committed after STOP
// (R16) only low address nibble increments
// (R17) overflow wraps, last sixteen bytes kept
// (R18) protect pin blocks writes to upper half
// (R19) protected writes acknowledged, array unchanged
// (R20) protected writes still take full cycle time
// (R21) master polls with control byte until acknowledged
// (R22) write cycle timed by parameterised counter
module see_slave #(
    parameter int WRITE_CYCLES = `SEE_TWR_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    see_bus_if.slave        link,
    input  wire logic [2:0] chipSel,
    input  wire logic       writeProtect,
    input  wire logic [7:0] readAddr,
    output logic [7:0]      readData,
    output logic            writeBusy
);
    see_pkg::see_slv_state_e state_ff;
    see_pkg::see_slv_stage_e stage_ff;
    see_pkg::see_slv_stage_e nxt_stage;
    logic [1:0]  sclSync_ff;
    logic [1:0]  sdaSync_ff;
    logic [3:0]  pinMeta_ff;
    logic [3:0]  pinSync_ff;
    logic        sclPrev_ff;
    logic        sdaPrev_ff;
    logic [3:0]  bitCnt_ff;
    logic [7:0]  shift_ff;
    logic        ackOe_ff;
    logic        sdaOut_ff;
    logic [7:0]  ptr_ff;
    logic [7:0]  page_ff [`SEE_PAGE_BYTES];
    logic [15:0] valid_ff;
    logic [7:0]  array_ff [256];
    logic [23:0] busyCnt_ff;
    logic        sclHigh;
    logic        sclRise;
    logic        sclFall;
    logic        startDet;
    logic        stopDet;
    logic        byteEnd;
    logic        ackNow;
    logic        byteTaken;
    logic        commit;
    logic        protect;

    // does a control byte address this device
    function automatic logic ctrlHit(input logic [7:0] ctrl, input logic [2:0] sel);
        return ctrl[7:4] == `SEE_DEV_CODE && ctrl[3:1] == sel;
    endfunction : ctrlHit

    assign link.sSdaOe  = ackOe_ff;
    assign link.sSdaOut = sdaOut_ff;

    // two-flop synchronisers for the link and the strap pins
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sclSync_ff <= 2'h3;
            sdaSync_ff <= 2'h3;
            pinMeta_ff <= 4'h0;
            pinSync_ff <= 4'h0;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
            sdaOut_ff  <= 1'b0;
        end
        else
        begin
            sclSync_ff <= {sclSync_ff[0], link.scl};
            sdaSync_ff <= {sdaSync_ff[0], link.sda};
            pinMeta_ff <= {writeProtect, chipSel};
            pinSync_ff <= pinMeta_ff;
            sclPrev_ff <= sclSync_ff[1];
            sdaPrev_ff <= sdaSync_ff[1];
        end
    end

    // edges are seen a few ref_clk cycles late, well inside the scl phases
    assign sclHigh  = sclSync_ff[1];
    assign sclRise  = sclHigh & ~sclPrev_ff;
    assign sclFall  = ~sclHigh & sclPrev_ff;
    // data moving while clock stays high is framing, not data R01
    assign startDet = sclHigh & sclPrev_ff & sdaPrev_ff & ~sdaSync_ff[1]; // R02
    assign stopDet  = sclHigh & sclPrev_ff & ~sdaPrev_ff & sdaSync_ff[1]; // R03
    assign byteEnd  = state_ff == see_pkg::SS_RX && sclFall && bitCnt_ff == `SEE_ACK_BIT;

    // acknowledge decision for the byte just received
    always_comb
    begin
        ackNow    = 1'b0;
        nxt_stage = see_pkg::SG_DATA;
        case (stage_ff)
            see_pkg::SG_CTRL:
            begin
                ackNow    = ctrlHit(shift_ff, pinSync_ff[2:0]) && !writeBusy; // R09 R11 R12
                nxt_stage = shift_ff[0] ? see_pkg::SG_READ : see_pkg::SG_ADDR; // R13
            end
            see_pkg::SG_ADDR: ackNow = 1'b1; // R14
            see_pkg::SG_DATA: ackNow = 1'b1; // R14 R19
            default: ackNow = 1'b0;
        endcase
    end

    assign byteTaken = byteEnd && ackNow;

    // bit receiver and acknowledge driver
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff  <= see_pkg::SS_IDLE;
            stage_ff  <= see_pkg::SG_CTRL;
            bitCnt_ff <= 4'h0;
            shift_ff  <= 8'h00;
            ackOe_ff  <= 1'b0;
        end
        else if (startDet)
        begin
            // a start, repeated or not, always restarts at the control byte
            state_ff  <= see_pkg::SS_RX;
            stage_ff  <= see_pkg::SG_CTRL;
            bitCnt_ff <= 4'h0;
            ackOe_ff  <= 1'b0;
        end
        else if (stopDet)
        begin
            state_ff <= see_pkg::SS_IDLE;
            ackOe_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                see_pkg::SS_RX:
                    if (sclRise && bitCnt_ff != `SEE_ACK_BIT)
                    begin
                        shift_ff  <= {shift_ff[6:0], sdaSync_ff[1]}; // R06
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                    else if (byteEnd)
                    begin
                        if (ackNow)
                        begin
                            ackOe_ff <= 1'b1; // R07 R08
                            state_ff <= see_pkg::SS_ACK;
                            stage_ff <= nxt_stage;
                        end
                        else
                            state_ff <= see_pkg::SS_IDLE; // R12
                    end
                see_pkg::SS_ACK:
                    if (sclFall)
                    begin
                        // low held over the whole high phase, released after fall R08
                        ackOe_ff  <= 1'b0; // R10
                        bitCnt_ff <= 4'h0;
                        state_ff  <= (stage_ff == see_pkg::SG_READ)
                                     ? see_pkg::SS_IDLE : see_pkg::SS_RX;
                    end
                default: ackOe_ff <= 1'b0;
            endcase
        end
    end

    // address pointer and page buffer
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ptr_ff   <= 8'h00;
            valid_ff <= 16'h0000;
            for (int i = 0; i < `SEE_PAGE_BYTES; i++)
                page_ff[i] <= 8'h00;
        end
        else if (startDet || stopDet)
            valid_ff <= 16'h0000; // a start without stop abandons the buffered write
        else if (byteTaken && stage_ff == see_pkg::SG_ADDR)
            ptr_ff <= shift_ff; // R14
        else if (byteTaken && stage_ff == see_pkg::SG_DATA)
        begin
            // a seventeenth byte lands on the first slot again R15 R17
            page_ff[ptr_ff[3:0]]  <= shift_ff;
            valid_ff[ptr_ff[3:0]] <= 1'b1;
            ptr_ff[3:0]           <= ptr_ff[3:0] + 4'h1; // R16
        end
    end

    // whole page shares one half, so one protect decision covers it
    assign protect = pinSync_ff[3] && ptr_ff[`SEE_PROT_BIT]; // R18
    assign commit  = stopDet && valid_ff != 16'h0000 && !writeBusy; // R14 R15

    // array update at the stop that ends a write
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            readData <= 8'h00;
            for (int i = 0; i < 256; i++)
                array_ff[i] <= 8'h00;
        end
        else
        begin
            readData <= array_ff[readAddr];
            if (commit && !protect) // R18 R19
                for (int i = 0; i < `SEE_PAGE_BYTES; i++)
                    if (valid_ff[i])
                        array_ff[{ptr_ff[7:4], 4'(i)}] <= page_ff[i];
        end
    end

    // self-timed write cycle, also run for a blocked write
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            writeBusy  <= 1'b0;
            busyCnt_ff <= 24'h000000;
        end
        else if (commit)
        begin
            writeBusy  <= 1'b1; // R20 R22
            busyCnt_ff <= 24'h000000;
        end
        else if (writeBusy)
        begin
            busyCnt_ff <= busyCnt_ff + 24'h000001;
            if (busyCnt_ff == 24'(WRITE_CYCLES - 1))
                writeBusy <= 1'b0; // R21 R22
        end
    end
endmodule : see_slave

// [see_link_properties.sv]
// link checker: framing, acknowledge slot and slave open-drain rules of the two-wire bus
`timescale 1ns/10ps
module see_link_properties (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic mSdaOut,
    input wire logic mSdaOe,
    input wire logic sSdaOut,
    input wire logic sSdaOe,
    input wire logic sda
);
    logic       sclQ_ff;
    logic       sdaQ_ff;
    logic [3:0] bitCnt_ff;
    logic [3:0] nxt_bitCnt;
    logic       startEv;
    logic       stopEv;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // data moving under a high clock is framing, judged against the previous sample
    assign startEv = scl && sclQ_ff && sdaQ_ff && !sda;
    assign stopEv  = scl && sclQ_ff && !sdaQ_ff && sda;
    // slot counter cleared by START, so slot 8 is the acknowledge of every byte
    assign nxt_bitCnt = startEv ? 4'h0 : (scl && !sclQ_ff) ?
                        ((bitCnt_ff == 4'h8) ? 4'h0 : bitCnt_ff + 4'h1) : bitCnt_ff;
    // idle bus reads high on both lines
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sclQ_ff   <= 1'b1;
            sdaQ_ff   <= 1'b1;
            bitCnt_ff <= 4'h0;
        end
        else
        begin
            sclQ_ff   <= scl;
            sdaQ_ff   <= sda;
            bitCnt_ff <= nxt_bitCnt;
        end
    end
    sequence ackHeld;
        sSdaOe [*4];
    endsequence
    sequence clkDrop;
        ##[1:4] !scl;
    endsequence
    ackSlot_a: assert property ($rose(sSdaOe) |-> bitCnt_ff == 4'h8)
        else $error("acknowledge driven outside the ninth slot");
    ackHold_a: assert property ($rose(scl) && sSdaOe |-> ackHeld)
        else $error("acknowledge low not held through clock high");
    ackFree_a: assert property ($rose(sSdaOe) |-> ##[4:12] !sSdaOe)
        else $error("slave did not release data after acknowledge");
    slaveLow_a: assert property ($changed(sSdaOe) |-> !scl)
        else $error("slave moved data while clock high");
    slaveOd_a: assert property (sSdaOe |-> !sSdaOut)
        else $error("slave drives data high");
    startIdle_a: assert property (startEv |-> $past(scl, 2))
        else $error("start without clock high before it");
    startClk_a: assert property (startEv |-> clkDrop)
        else $error("no clock pulse after start");
    stopIdle_a: assert property (stopEv |-> (scl && sda) [*2])
        else $error("bus not idle after stop");
    masterAckSlot_a: assert property ($rose(scl) && bitCnt_ff == 4'h8
        |-> mSdaOut || !mSdaOe)
        else $error("master pulls data low in the acknowledge slot");
endmodule : see_link_properties

// [see_tb_top.sv]
// bench: master and eeprom slave joined on one link, array checked through the peek port
`timescale 1ns/10ps
module see_tb_top;
    localparam int WCYC = 200;
    typedef struct packed {logic wp; logic [7:0] adr; logic [7:0] cnt; logic [7:0] base;} see_row_s;
    logic       ref_clk      = 1'b0;
    logic       reset        = 1'b1;
    logic [2:0] devSel       = 3'h5;
    logic [2:0] chipSel      = 3'h5;
    logic       writeProtect = 1'b0;
    logic [7:0] wrData       = 8'h00;
    logic       wrLast       = 1'b0;
    logic       wrValid      = 1'b0;
    logic [7:0] readAddr     = 8'h00;
    logic       wrReady, busy, nackErr, writeBusy, flagSeen;
    logic [7:0] readData;
    logic [7:0] mem [256];
    int         bad_count       = 0;
    int         samples_checked = 0;
    // rows: protect pin, word address, data count, first data value
    see_row_s rows [6] = '{'{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b0, 8'h05, 8'h01, 8'h11},
        '{1'b0, 8'h3C, 8'h10, 8'h40}, '{1'b1, 8'h80, 8'h02, 8'h77},
        '{1'b1, 8'h7E, 8'h14, 8'hC0}, '{1'b0, 8'hF0, 8'h03, 8'h99}};
    see_bus_if link ();
    see_master i_see_master (.ref_clk(ref_clk), .reset(reset), .link(link), .devSel(devSel),
        .wrData(wrData), .wrLast(wrLast), .wrValid(wrValid), .wrReady(wrReady), .busy(busy),
        .nackErr(nackErr));
    see_slave #(.WRITE_CYCLES(WCYC)) i_see_slave (.ref_clk(ref_clk), .reset(reset), .link(link),
        .chipSel(chipSel), .writeProtect(writeProtect), .readAddr(readAddr),
        .readData(readData), .writeBusy(writeBusy));
    see_link_properties i_see_link_properties (.ref_clk(ref_clk), .reset(reset),
        .scl(link.scl), .mSdaOut(link.mSdaOut), .mSdaOe(link.mSdaOe),
        .sSdaOut(link.sSdaOut), .sSdaOe(link.sSdaOe), .sda(link.sda));
    // 25 MHz reference
    always #20 ref_clk = ~ref_clk;
    task automatic finish_test;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : checkVal
    // offer one queue word and hold it until the queue has room; a bounded wait
    task automatic pushWord(input logic [7:0] d, input logic l);
        int n;
        n = 0;
        wrData = d;
        wrLast = l;
        wrValid = 1'b1;
        while (wrReady !== 1'b1)
        begin
            flagSeen = 1'b1;
            @(negedge ref_clk);
            n++;
            if (n > 2000)
            begin
                bad_count++;
                finish_test();
            end
        end
        @(negedge ref_clk);
    endtask : pushWord
    // one write command, then wait out the write cycle and the master's polling
    task automatic runCmd(input see_row_s r);
        int n;
        int wb;
        logic prevWb;
        logic nk;
        logic ab;
        n = 0;
        wb = 0;
        prevWb = 1'b0;
        nk = 1'b0;
        ab = 1'b0;
        pushWord(r.adr, r.cnt == 8'h00);
        for (int i = 0; i < r.cnt; i++) pushWord(r.base + i[7:0], i == r.cnt - 1);
        wrValid = 1'b0;
        while ((busy === 1'b1 || n < 4) && n < 30000)
        begin
            @(negedge ref_clk);
            n++;
            wb += (writeBusy === 1'b1);
            nk |= (nackErr === 1'b1);
            ab |= (writeBusy === 1'b1 && link.sSdaOe === 1'b1);
            if (prevWb && writeBusy === 1'b0) checkVal(busy, 1);
            prevWb = (writeBusy === 1'b1);
        end
        if (n >= 30000)
        begin
            bad_count++;
            finish_test();
        end
        if (!(r.wp && r.adr[7]))
            for (int i = 0; i < r.cnt; i++) mem[{r.adr[7:4], r.adr[3:0] + i[3:0]}] = r.base + i[7:0];
        checkVal(wb, (r.cnt != 8'h00) ? WCYC : 0);
        checkVal(nk, 0);
        checkVal(ab, 0);
    endtask : runCmd
    // peek the whole array: catches writes that landed where they must not
    task automatic checkMem;
        for (int a = 0; a < 256; a++)
        begin
            readAddr = a[7:0];
            @(negedge ref_clk);
            checkVal(readData, mem[a]);
        end
    endtask : checkMem
    // ordinary rows, then select mismatch and a second reset
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
        flagSeen = 1'b0;
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        foreach (rows[k])
        begin
            writeProtect = rows[k].wp;
            repeat (4) @(negedge ref_clk);
            runCmd(rows[k]);
            checkMem();
        end
        checkVal(flagSeen, 1);
        devSel = 3'h4;
        pushWord(8'h20, 1'b0);
        pushWord(8'hAA, 1'b1);
        wrValid = 1'b0;
        flagSeen = 1'b0;
        repeat (800)
        begin
            @(negedge ref_clk);
            flagSeen |= (link.sSdaOe === 1'b1 || writeBusy === 1'b1);
        end
        checkVal(flagSeen, 0);
        reset = 1'b1;
        chipSel = 3'h4;
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        checkVal({busy, writeBusy}, 0);
        foreach (mem[i]) mem[i] = 8'h00;
        runCmd(see_row_s'{1'b0, 8'h20, 8'h01, 8'h5A});
        checkMem();
        finish_test();
    end
endmodule : see_tb_top
